// *** core/eep_slave.sv ***
// Two-wire serial EEPROM slave: page write, write cycle, polling and reads.
`timescale 1ns/1ps
module eep_slave
	import eep_pkg::*;
#(
	parameter int ARRAY_BYTES   = 256,
	parameter int PAGE_BYTES    = 8,
	parameter int ADDR_BYTES    = 1,
	parameter bit HAS_CS_PINS   = 1'b1,
	parameter int WRITE_TIME_NS = 5000000
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic link_clk,
	input  wire logic scl,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	input  wire logic wp,
	input  wire logic chip_select_bit_2,
	input  wire logic chip_select_bit_1,
	input  wire logic chip_select_bit_0,
	output logic      write_busy
);
	// Widths follow the variant chosen by parameter
	localparam int AW           = $clog2(ARRAY_BYTES);
	localparam int PW           = $clog2(PAGE_BYTES);
	localparam int WRITE_CYCLES = (WRITE_TIME_NS + EEP_CLK_PERIOD_NS - 1) / EEP_CLK_PERIOD_NS;
	localparam int WC_W         = $clog2(WRITE_CYCLES + 1);
	localparam logic [1:0] ADDR_LAST = 2'(ADDR_BYTES - 1);

	function automatic logic [AW-1:0] page_next(input logic [AW-1:0] a);
		page_next = {a[AW-1:PW], PW'(a[PW-1:0] + PW'(1))};
	endfunction

	eep_link_in_t    lin_raw;
	eep_link_in_t    lin_s;
	logic            tgl_s;
	logic            wc_busy_r;
	logic            wc_seen_r;
	logic [WC_W-1:0] wc_cnt_r;
	logic            wr_tgl_r;

	assign lin_raw = '{scl: scl, sda: sda_in, wp: wp, rst: rst,
		cs: {chip_select_bit_2, chip_select_bit_1, chip_select_bit_0}, busy: wc_busy_r};

	eep_sync3 #(.W(EEP_LINK_IN_W)) u_link_sync (
		.clk_i (link_clk),
		.d     (lin_raw),
		.q     (lin_s)
	);

	eep_sync3 #(.W(1)) u_tgl_sync (
		.clk_i (clk),
		.d     (wr_tgl_r),
		.q     (tgl_s)
	);

	// System domain: write cycle timer
	always_ff @(posedge clk) begin
		if (rst) begin
			wc_busy_r <= 1'b0;
			wc_seen_r <= 1'b0;
			wc_cnt_r  <= '0;
		end else if (tgl_s != wc_seen_r) begin
			wc_seen_r <= tgl_s;
			wc_busy_r <= 1'b1;
			wc_cnt_r  <= WC_W'(WRITE_CYCLES);
		end else if (wc_busy_r) begin
			wc_cnt_r <= wc_cnt_r - WC_W'(1);
			if (wc_cnt_r == WC_W'(1)) begin
				wc_busy_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			write_busy <= 1'b0;
		end else begin
			write_busy <= wc_busy_r;
		end
	end

	// Link domain
	logic                link_rst;
	logic                scl_q_r;
	logic                sda_q_r;
	logic                wp_lat_r;
	eep_state_t          state_r;
	eep_wr_phase_t       wr_phase_r;
	logic [3:0]          bit_cnt_r;
	logic [7:0]          sh_r;
	logic [7:0]          tx_r;
	logic                rd_dir_r;
	logic                mack_r;
	logic [1:0]          addr_cnt_r;
	logic [15:0]         addr_sh_r;
	logic [15:0]         addr_sh_nxt;
	logic [AW-1:0]       addr_r;
	logic [AW-PW-1:0]    wr_page_r;
	logic [7:0]          buf_r [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] valid_r;
	logic [7:0]          mem_r [ARRAY_BYTES];

	logic rise, fall, start_c, stop_c, rx_state, byte_done, link_busy;
	logic ctrl_ok, rd_load, data_byte, addr_last, commit, stop_write;
	logic [7:0] rd_byte;

	assign link_rst  = lin_s.rst;
	assign rise      = lin_s.scl & ~scl_q_r;
	assign fall      = ~lin_s.scl & scl_q_r;
	assign start_c   = lin_s.scl & scl_q_r & sda_q_r & ~lin_s.sda;
	assign stop_c    = lin_s.scl & scl_q_r & ~sda_q_r & lin_s.sda;
	assign rx_state  = state_r inside {EEP_ST_CTRL, EEP_ST_ADDR, EEP_ST_WDATA};
	assign byte_done = fall && rx_state && bit_cnt_r == EEP_BYTE_BITS;
	assign link_busy = wr_phase_r != EEP_WR_IDLE;
	assign ctrl_ok   = sh_r[EEP_CODE_MSB:EEP_CODE_LSB] == EEP_CTRL_CODE &&
		(!HAS_CS_PINS || sh_r[EEP_CS_MSB:EEP_CS_LSB] == lin_s.cs) && !link_busy;
	assign rd_byte   = mem_r[addr_r];
	assign rd_load   = fall && ((state_r == EEP_ST_CTRL_ACK && rd_dir_r) ||
		(state_r == EEP_ST_RACK && mack_r));
	assign data_byte = byte_done && state_r == EEP_ST_WDATA;
	assign addr_last = byte_done && state_r == EEP_ST_ADDR && addr_cnt_r == ADDR_LAST;
	assign addr_sh_nxt = {addr_sh_r[7:0], sh_r};
	assign commit    = wr_phase_r == EEP_WR_WAIT_LO && !lin_s.busy;
	assign stop_write = stop_c && (|valid_r) && !link_busy;

	always_ff @(posedge link_clk) begin
		scl_q_r  <= lin_s.scl;
		sda_q_r  <= lin_s.sda;
		wp_lat_r <= lin_s.wp;
	end

	always_ff @(posedge link_clk) begin
		sda_out <= 1'b0;
	end

	// Protocol engine; bus changes are only made after a falling clock
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			state_r    <= EEP_ST_IDLE;
			bit_cnt_r  <= EEP_BIT_RST;
			sh_r       <= EEP_BYTE_RST;
			tx_r       <= EEP_BYTE_RST;
			sda_oe     <= 1'b0;
			rd_dir_r   <= 1'b0;
			mack_r     <= 1'b0;
			addr_cnt_r <= EEP_ACNT_RST;
		end else if (start_c) begin
			state_r   <= EEP_ST_CTRL;
			bit_cnt_r <= EEP_BIT_RST;
			sda_oe    <= 1'b0;
		end else if (stop_c) begin
			state_r <= EEP_ST_IDLE;
			sda_oe  <= 1'b0;
		end else begin
			if (rise && rx_state && bit_cnt_r != EEP_BYTE_BITS) begin
				sh_r      <= {sh_r[6:0], lin_s.sda};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
			unique case (state_r)
				EEP_ST_IDLE: begin
				end
				EEP_ST_CTRL: begin
					if (byte_done) begin
						rd_dir_r <= sh_r[EEP_DIR_BIT] == EEP_DIR_READ;
						sda_oe   <= ctrl_ok;
						state_r  <= ctrl_ok ? EEP_ST_CTRL_ACK : EEP_ST_IDLE;
					end
				end
				EEP_ST_CTRL_ACK: begin
					if (fall) begin
						bit_cnt_r  <= EEP_BIT_RST;
						addr_cnt_r <= EEP_ACNT_RST;
						if (rd_dir_r) begin
							tx_r    <= rd_byte;
							sda_oe  <= ~rd_byte[7];
							state_r <= EEP_ST_RDATA;
						end else begin
							sda_oe  <= 1'b0;
							state_r <= EEP_ST_ADDR;
						end
					end
				end
				EEP_ST_ADDR: begin
					if (byte_done) begin
						sda_oe  <= 1'b1;
						state_r <= EEP_ST_ADDR_ACK;
					end
				end
				EEP_ST_ADDR_ACK: begin
					if (fall) begin
						sda_oe     <= 1'b0;
						bit_cnt_r  <= EEP_BIT_RST;
						addr_cnt_r <= addr_cnt_r + 2'h1;
						state_r    <= (addr_cnt_r == ADDR_LAST) ? EEP_ST_WDATA : EEP_ST_ADDR;
					end
				end
				EEP_ST_WDATA: begin
					if (byte_done) begin
						sda_oe  <= 1'b1;
						state_r <= EEP_ST_WDATA_ACK;
					end
				end
				EEP_ST_WDATA_ACK: begin
					if (fall) begin
						sda_oe    <= 1'b0;
						bit_cnt_r <= EEP_BIT_RST;
						state_r   <= EEP_ST_WDATA;
					end
				end
				EEP_ST_RDATA: begin
					if (rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (fall) begin
						if (bit_cnt_r == EEP_BYTE_BITS) begin
							sda_oe  <= 1'b0;
							state_r <= EEP_ST_RACK;
						end else begin
							sda_oe <= ~tx_r[6];
							tx_r   <= {tx_r[6:0], 1'b0};
						end
					end
				end
				EEP_ST_RACK: begin
					if (rise) begin
						mack_r <= ~lin_s.sda;
						if (lin_s.sda) begin
							state_r <= EEP_ST_IDLE;
						end
					end else if (fall && mack_r) begin
						bit_cnt_r <= EEP_BIT_RST;
						tx_r      <= rd_byte;
						sda_oe    <= ~rd_byte[7];
						state_r   <= EEP_ST_RDATA;
					end
				end
				default: begin
					state_r <= EEP_ST_IDLE;
					sda_oe  <= 1'b0;
				end
			endcase
		end
	end

	// Address counter
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			addr_r    <= '0;
			addr_sh_r <= 16'h0000;
		end else if (byte_done && state_r == EEP_ST_ADDR) begin
			addr_sh_r <= addr_sh_nxt;
			if (addr_last) begin
				addr_r <= addr_sh_nxt[AW-1:0];
			end
		end else if (data_byte) begin
			addr_r <= page_next(addr_r);
		end else if (rd_load) begin
			addr_r <= addr_r + AW'(1);
		end
	end

	// Page buffer; a held page survives any traffic during the write cycle
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			valid_r   <= '0;
			wr_page_r <= '0;
		end else if (commit) begin
			valid_r <= '0;
		end else if (stop_write && wp_lat_r) begin
			valid_r <= '0;
		end else if (start_c && !link_busy) begin
			valid_r <= '0;
		end else if (data_byte) begin
			buf_r[addr_r[PW-1:0]]   <= sh_r;
			valid_r[addr_r[PW-1:0]] <= 1'b1;
			wr_page_r               <= addr_r[AW-1:PW];
		end
	end

	// Handshake with the write cycle timer
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			wr_phase_r <= EEP_WR_IDLE;
			wr_tgl_r   <= 1'b0;
		end else begin
			unique case (wr_phase_r)
				EEP_WR_IDLE: begin
					if (stop_write && !wp_lat_r) begin
						wr_tgl_r   <= ~wr_tgl_r;
						wr_phase_r <= EEP_WR_WAIT_HI;
					end
				end
				EEP_WR_WAIT_HI: begin
					if (lin_s.busy) begin
						wr_phase_r <= EEP_WR_WAIT_LO;
					end
				end
				EEP_WR_WAIT_LO: begin
					if (!lin_s.busy) begin
						wr_phase_r <= EEP_WR_IDLE;
					end
				end
				default: begin
					wr_phase_r <= EEP_WR_IDLE;
				end
			endcase
		end
	end

	// Array is committed at the end of the write cycle
	always_ff @(posedge link_clk) begin
		if (commit) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (valid_r[i]) begin
					mem_r[{wr_page_r, PW'(i)}] <= buf_r[i];
				end
			end
		end
	end

	property p_ctrl_nack_busy;
		@(posedge link_clk) disable iff (link_rst)
		(state_r == EEP_ST_CTRL && byte_done && link_busy && !start_c && !stop_c)
			|=> !sda_oe && state_r == EEP_ST_IDLE;
	endproperty
	a_ctrl_nack_busy: assert property (p_ctrl_nack_busy) else $error("ack while busy");

	property p_ctrl_ack;
		@(posedge link_clk) disable iff (link_rst)
		(state_r == EEP_ST_CTRL && byte_done && ctrl_ok && !start_c && !stop_c)
			|=> sda_oe && state_r == EEP_ST_CTRL_ACK;
	endproperty
	a_ctrl_ack: assert property (p_ctrl_ack) else $error("valid control not acked");

	property p_code_check;
		@(posedge link_clk) disable iff (link_rst)
		$rose(state_r == EEP_ST_CTRL_ACK) |-> $past(sh_r[7:4]) == EEP_CTRL_CODE;
	endproperty
	a_code_check: assert property (p_code_check) else $error("wrong code acked");

	property p_page_wrap;
		@(posedge link_clk) disable iff (link_rst)
		data_byte && !start_c && !stop_c |=> addr_r[AW-1:PW] == $past(addr_r[AW-1:PW]) &&
			addr_r[PW-1:0] == PW'($past(addr_r[PW-1:0]) + PW'(1));
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("page address step wrong");

	property p_wp_blocks;
		@(posedge link_clk) disable iff (link_rst)
		stop_write && wp_lat_r |=> wr_phase_r == EEP_WR_IDLE && valid_r == '0;
	endproperty
	a_wp_blocks: assert property (p_wp_blocks) else $error("protected write launched");

	property p_launch;
		@(posedge link_clk) disable iff (link_rst)
		stop_write && !wp_lat_r |=> wr_phase_r == EEP_WR_WAIT_HI ##1 link_busy;
	endproperty
	a_launch: assert property (p_launch) else $error("write cycle not started");

	property p_read_step;
		@(posedge link_clk) disable iff (link_rst)
		rd_load && !start_c && !stop_c |=> addr_r == AW'($past(addr_r) + AW'(1)) &&
			tx_r == $past(rd_byte);
	endproperty
	a_read_step: assert property (p_read_step) else $error("read pointer not advanced");

	property p_wrap_zero;
		@(posedge link_clk) disable iff (link_rst)
		rd_load && !start_c && !stop_c && (&addr_r) |=> addr_r == '0;
	endproperty
	a_wrap_zero: assert property (p_wrap_zero) else $error("pointer did not wrap");

	property p_stop_release;
		@(posedge link_clk) disable iff (link_rst)
		stop_c |=> !sda_oe [*2];
	endproperty
	a_stop_release: assert property (p_stop_release) else $error("drive after stop");

	property p_busy_len;
		@(posedge clk) disable iff (rst)
		$rose(wc_busy_r) |-> wc_busy_r [*4];
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("write cycle too short");

	c_page_write: cover property (@(posedge link_clk) disable iff (link_rst)
		stop_write && !wp_lat_r);
	c_seq_read: cover property (@(posedge link_clk) disable iff (link_rst)
		state_r == EEP_ST_RACK && fall && mack_r);
	c_poll_nack: cover property (@(posedge link_clk) disable iff (link_rst)
		state_r == EEP_ST_CTRL && byte_done && link_busy);
	c_commit: cover property (@(posedge link_clk) disable iff (link_rst) commit);
endmodule // eep_slave

// *** core/eep_pkg.sv ***
// Shared constants and types for the serial EEPROM slave.
package eep_pkg;

	// Control byte fields
	localparam logic [3:0] EEP_CTRL_CODE  = 4'ha;
	localparam logic       EEP_DIR_READ   = 1'b1;
	localparam int         EEP_CODE_MSB   = 7;
	localparam int         EEP_CODE_LSB   = 4;
	localparam int         EEP_CS_MSB     = 3;
	localparam int         EEP_CS_LSB     = 1;
	localparam int         EEP_DIR_BIT    = 0;

	// Bit counting within one byte
	localparam logic [3:0] EEP_BYTE_BITS  = 4'h8;

	// System clock
	localparam int         EEP_CLK_PERIOD_NS = 40;

	// Reset values
	localparam logic [7:0] EEP_BYTE_RST   = 8'h00;
	localparam logic [3:0] EEP_BIT_RST    = 4'h0;
	localparam logic [1:0] EEP_ACNT_RST   = 2'h0;

	typedef enum logic [8:0] {
		EEP_ST_IDLE      = 9'h001,
		EEP_ST_CTRL      = 9'h002,
		EEP_ST_CTRL_ACK  = 9'h004,
		EEP_ST_ADDR      = 9'h008,
		EEP_ST_ADDR_ACK  = 9'h010,
		EEP_ST_WDATA     = 9'h020,
		EEP_ST_WDATA_ACK = 9'h040,
		EEP_ST_RDATA     = 9'h080,
		EEP_ST_RACK      = 9'h100
	} eep_state_t;

	typedef enum logic [2:0] {
		EEP_WR_IDLE    = 3'h1,
		EEP_WR_WAIT_HI = 3'h2,
		EEP_WR_WAIT_LO = 3'h4
	} eep_wr_phase_t;

	// Everything the link domain samples from outside
	typedef struct packed {
		logic       scl;
		logic       sda;
		logic       wp;
		logic       rst;
		logic [2:0] cs;
		logic       busy;
	} eep_link_in_t;

	localparam int EEP_LINK_IN_W = $bits(eep_link_in_t);

endpackage

// *** core/eep_sync3.sv ***
// Three-stage input synchroniser, output moves once stages two and three agree.
`timescale 1ns/1ps
module eep_sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge clk_i) begin
		s1_r <= d;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	// Disagreeing bits hold their last settled value
	always_ff @(posedge clk_i) begin
		q <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q);
	end
endmodule // eep_sync3

// *** tb/eep_master.sv ***
// Two-wire bus master model that drives the device's bus pins.
`timescale 1ns/1ps
module eep_master (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	initial begin
		scl      = 1'b1;
		sda_pull = 1'b0;
	end

	// Quarter bit of 8 clocks keeps both bus phases well above the sync delay
	task automatic q();
		repeat (8) @(negedge clk);
	endtask

	// Also used as repeated Start, which keeps the loaded address
	task automatic start();
		sda_pull = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_pull = 1'b1;
		q();
		scl = 1'b0;
		q();
	endtask

	task automatic stop();
		sda_pull = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_pull = 1'b0;
		q();
	endtask

	task automatic bitx(input logic b, output logic s);
		sda_pull = ~b;
		q();
		scl = 1'b1;
		q();
		s = sda;
		q();
		scl = 1'b0;
		q();
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], s);
		end
		bitx(1'b1, s);
		ack = ~s;
	endtask

	// Master ack asks for the next byte, nack ends the read
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, s);
			d[i] = s;
		end
		bitx(~more, s);
	endtask
endmodule // eep_master

// *** tb/eep_slave_bench.sv ***
// Self-checking bench for the serial EEPROM slave.
`timescale 1ns/1ps
module eep_slave_bench;
	import eep_pkg::*;
	logic       clk;
	logic       link_clk;
	logic       rst;
	logic       wp;
	logic [2:0] cs_pins;
	logic       scl;
	logic       m_pull;
	logic       s_oe;
	logic       s_out;
	logic       busy;
	wire        sda;
	logic [7:0] cw;
	logic [7:0] cr;
	logic [7:0] mdl [256];
	logic [7:0] ptr;
	logic [7:0] exp_q [$];
	logic [7:0] exp_v;
	logic [7:0] seen;
	string      seen_name;
	event       got;
	int         seed;
	int         err_total;
	int         comparisons;
	int         cycles;

	// Open-drain wire with pull-up
	assign sda = !(m_pull || (s_oe && !s_out));
	assign cw  = {EEP_CTRL_CODE, cs_pins, 1'b0};
	assign cr  = {EEP_CTRL_CODE, cs_pins, 1'b1};

	eep_master m (.clk(clk), .sda(sda), .scl(scl), .sda_pull(m_pull));

	eep_slave #(.ARRAY_BYTES(256), .PAGE_BYTES(8), .ADDR_BYTES(1), .HAS_CS_PINS(1'b1),
		.WRITE_TIME_NS(20000)) dut (
		.clk(clk), .rst(rst), .link_clk(link_clk), .scl(scl), .sda_in(sda),
		.sda_out(s_out), .sda_oe(s_oe), .wp(wp), .chip_select_bit_2(cs_pins[2]),
		.chip_select_bit_1(cs_pins[1]), .chip_select_bit_0(cs_pins[0]), .write_busy(busy));

	always #20 clk = ~clk;

	initial begin
		link_clk = 1'b0;
		#7;
		forever #16 link_clk = ~link_clk;
	end

	always @(got) begin
		comparisons++;
		exp_v = exp_q.pop_front();
		if (exp_v !== seen) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", seen_name, exp_v, seen);
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_total++;
			$display("FAIL run length expected finish seen hang");
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
		exp_q.push_back(e);
		seen      = s;
		seen_name = what;
		->got;
		// Let the checker take this note before a second check in the same step
		#1;
	endtask

	task automatic ctl(input logic [7:0] c, input logic e);
		logic k;
		m.start();
		m.wbyte(c, k);
		chk("control ack", {7'h0, e}, {7'h0, k});
	endtask

	// Page write of n random bytes, then Stop and acknowledge polling
	task automatic pw(input logic [7:0] a, input int n, input logic pro);
		logic [7:0] d;
		logic       k;
		int         i;
		wp = pro;
		ctl(cw, 1'b1);
		m.wbyte(a, k);
		chk("address ack", 8'h01, {7'h0, k});
		for (i = 0; i < n; i++) begin
			d = 8'($random(seed));
			m.wbyte(d, k);
			chk("data ack", 8'h01, {7'h0, k});
			if (!pro)
				mdl[{a[7:3], 3'(a[2:0] + i[2:0])}] = d;
		end
		m.stop();
		// Protect flips after Stop; must not touch the running cycle
		wp = ~pro;
		repeat (16) @(negedge clk);
		chk("busy after stop", {7'h0, ~pro}, {7'h0, busy});
		m.start();
		m.wbyte(cw, k);
		chk("first poll", {7'h0, pro}, {7'h0, k});
		for (i = 0; i < 20 && !k; i++) begin
			m.start();
			m.wbyte(cw, k);
		end
		chk("poll ack", 8'h01, {7'h0, k});
		m.stop();
		chk("busy when done", 8'h00, {7'h0, busy});
		wp = 1'b0;
		ptr = {a[7:3], 3'(a[2:0] + n[2:0])};
	endtask

	// Random read when ra is set, else current address; n bytes in sequence
	task automatic rd(input logic ra, input logic [7:0] a, input int n);
		logic [7:0] d;
		logic       k;
		if (ra) begin
			ctl(cw, 1'b1);
			m.wbyte(a, k);
			chk("address ack", 8'h01, {7'h0, k});
			ptr = a;
		end
		ctl(cr, 1'b1);
		for (int i = 0; i < n; i++) begin
			m.rbyte(i < n - 1, d);
			chk("read data", mdl[ptr], d);
			ptr = ptr + 8'h01;
		end
		m.stop();
	endtask

	initial begin
		seed        = 21871;
		clk         = 1'b0;
		rst         = 1'b1;
		wp          = 1'b0;
		err_total   = 0;
		comparisons = 0;
		cycles      = 0;
		ptr         = 8'h00;
		cs_pins     = 3'($random(seed));
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		chk("busy after reset", 8'h00, {7'h0, busy});
		pw(8'h10, 8, 1'b0);
		pw(8'h1e, 10, 1'b0);
		pw(8'h12, 3, 1'b0);
		pw(8'h14, 1, 1'b1);
		$display("test page writes done");
		rd(1'b1, 8'h10, 1);
		rd(1'b0, 8'h00, 15);
		$display("test reads done");
		pw(8'hff, 1, 1'b0);
		pw(8'h00, 1, 1'b0);
		rd(1'b1, 8'hff, 2);
		$display("test address wrap done");
		for (int i = 0; i < 8; i++) begin
			ctl({EEP_CTRL_CODE, i[2:0], 1'b0}, i[2:0] == cs_pins);
			m.stop();
		end
		ctl({4'hb, cs_pins, 1'b0}, 1'b0);
		m.stop();
		$display("test select refusal done");
		tally_and_finish();
	end
endmodule // eep_slave_bench
